// ---- core/cfg_hdr_pkg.sv ----
// Constants and carriers for the primary status and class code registers.
// Assumes a single core clock and a simple configuration access port.
package cfg_hdr_pkg;
  // Configuration offsets (byte addresses)
  localparam logic [7:0] STATUS_OFFSET = 8'h06;
  localparam logic [7:0] CLASS_OFFSET = 8'h08;
  localparam logic [7:0] COMMAND_OFFSET = 8'h04;
  // Status field positions
  localparam int DETECTED_POISON_BIT = 15;
  localparam int SIGNALED_SYSERR_BIT = 14;
  localparam int RECEIVED_UR_BIT = 13;
  localparam int RECEIVED_CA_BIT = 12;
  localparam int SIGNALED_CA_BIT = 11;
  localparam int MASTER_POISON_BIT = 8;
  localparam int CAP_LIST_BIT = 4;
  // Command field positions
  localparam int SYSERR_ENABLE_BIT = 8;
  localparam int PARITY_ENABLE_BIT = 6;
  // Reset values and fixed fields
  localparam logic [15:0] STATUS_RESET = 16'h0010;
  localparam logic [15:0] STATUS_FLAG_MASK = 16'hF900;
  localparam logic [7:0] BASE_CLASS_CODE = 8'h06;
  localparam logic [7:0] SUB_CLASS_CODE = 8'h04;
  localparam logic [7:0] PROGRAMMING_INTERFACE_CODE = 8'h00;
  // Revision default is arbitrary
  localparam logic [7:0] SILICON_REVISION_DEFAULT = 8'h5A;

  // Link events, one-cycle pulses
  typedef struct packed {
    logic poisoned_tlp;
    logic error_msg_sent;
    logic cpl_unsupported;
    logic cpl_abort_rcvd;
    logic cpl_abort_sent;
    logic poisoned_cpl_data;
    logic write_poisoned;
  } link_event_s;

  // Configuration request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] offset;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } cfg_req_s;

  // Configuration answer
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } cfg_rsp_s;
endpackage

// ---- core/primary_status_class_regs.sv ----
// Primary status and class code registers of the bridge header.
// Assumes config requests and link event pulses synchronous to clk.
`timescale 1ns/100ps
module primary_status_class_regs #(
  parameter logic [7:0] SILICON_REVISION =
    cfg_hdr_pkg::SILICON_REVISION_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Command register bits from the header
  input wire logic [15:0] command_reg,
  // Link events
  input wire cfg_hdr_pkg::link_event_s link_evt,
  // Forwarding of received data towards the PCI side
  input wire logic fwd_valid,
  input wire logic fwd_poisoned,
  output logic fwd_bad_parity,
  // Configuration access
  input wire cfg_hdr_pkg::cfg_req_s cfg_req,
  output cfg_hdr_pkg::cfg_rsp_s cfg_rsp
);
  import cfg_hdr_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic bad_parity;
  } state_s;
  state_s st_q;
  state_s st_d;

  logic [15:0] set_vec;
  logic [15:0] clr_vec;
  logic [15:0] flag_vec;
  logic [15:0] status_val;
  logic [31:0] class_val;
  logic parity_en;
  logic syserr_en;
  logic sel_status;

  assign parity_en = command_reg[PARITY_ENABLE_BIT];
  assign syserr_en = command_reg[SYSERR_ENABLE_BIT];

  // Events that set each flag
  always_comb begin
    set_vec = 16'h0000;
    set_vec[DETECTED_POISON_BIT] = link_evt.poisoned_tlp;
    set_vec[SIGNALED_SYSERR_BIT] = link_evt.error_msg_sent & syserr_en;
    set_vec[RECEIVED_UR_BIT] = link_evt.cpl_unsupported;
    set_vec[RECEIVED_CA_BIT] = link_evt.cpl_abort_rcvd;
    set_vec[SIGNALED_CA_BIT] = link_evt.cpl_abort_sent;
    set_vec[MASTER_POISON_BIT] = parity_en &
      (link_evt.poisoned_cpl_data | link_evt.write_poisoned);
  end

  // Status sits in the upper half of the dword at 04h
  assign sel_status = (cfg_req.offset == COMMAND_OFFSET) ||
                      (cfg_req.offset == STATUS_OFFSET);

  // Write-one-to-clear from the upper byte lanes
  always_comb begin
    clr_vec = 16'h0000;
    if (cfg_req.wr && sel_status) begin
      if (cfg_req.byte_en[2]) begin
        clr_vec[7:0] = cfg_req.wdata[23:16];
      end
      if (cfg_req.byte_en[3]) begin
        clr_vec[15:8] = cfg_req.wdata[31:24];
      end
      clr_vec = clr_vec & STATUS_FLAG_MASK;
    end
  end

  // One sticky flag per error bit
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_flag
      if (STATUS_FLAG_MASK[gi]) begin : g_live
        sticky_flag u_flag (
          .clk(clk),
          .reset(reset),
          .set_evt(set_vec[gi]),
          .clr(clr_vec[gi]),
          .flag(flag_vec[gi])
        );
      end else begin : g_fixed
        assign flag_vec[gi] = 1'b0;
      end
    end
  endgenerate

  // Fixed fields are ORed over the live flags
  assign status_val = flag_vec | STATUS_RESET;
  assign class_val = {BASE_CLASS_CODE, SUB_CLASS_CODE,
                      PROGRAMMING_INTERFACE_CODE,
                      SILICON_REVISION};

  // Read mux, acknowledge and parity forwarding
  always_comb begin
    st_d = st_q;
    st_d.ack = cfg_req.rd | cfg_req.wr;
    st_d.rdata = 32'h0000_0000;
    if (cfg_req.rd) begin
      if (sel_status) begin
        st_d.rdata = {status_val, 16'h0000};
      end else if (cfg_req.offset == CLASS_OFFSET) begin
        st_d.rdata = class_val;
      end
    end
    st_d.bad_parity = fwd_valid & fwd_poisoned;
  end

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cfg_rsp.ack = st_q.ack;
  assign cfg_rsp.rdata = st_q.rdata;
  assign fwd_bad_parity = st_q.bad_parity;

  // Assertions
  property p_poison_sets;
    @(posedge clk) disable iff (reset)
    link_evt.poisoned_tlp |=> flag_vec[DETECTED_POISON_BIT];
  endproperty
  a_poison_sets: assert property (p_poison_sets)
    else $error("poisoned tlp did not set bit 15");

  property p_syserr_sets;
    @(posedge clk) disable iff (reset)
    (link_evt.error_msg_sent && syserr_en) |=>
      flag_vec[SIGNALED_SYSERR_BIT];
  endproperty
  a_syserr_sets: assert property (p_syserr_sets)
    else $error("error message did not set bit 14");

  property p_syserr_blocked;
    @(posedge clk) disable iff (reset)
    (!flag_vec[SIGNALED_SYSERR_BIT] && !syserr_en) |=>
      !flag_vec[SIGNALED_SYSERR_BIT];
  endproperty
  a_syserr_blocked: assert property (p_syserr_blocked)
    else $error("bit 14 set while reporting disabled");

  property p_ur_sets;
    @(posedge clk) disable iff (reset)
    link_evt.cpl_unsupported |=> flag_vec[RECEIVED_UR_BIT];
  endproperty
  a_ur_sets: assert property (p_ur_sets)
    else $error("unsupported completion did not set bit 13");

  property p_cpl_abort;
    @(posedge clk) disable iff (reset)
    (link_evt.cpl_abort_rcvd |=> flag_vec[RECEIVED_CA_BIT]) and
    (link_evt.cpl_abort_sent |=> flag_vec[SIGNALED_CA_BIT]);
  endproperty
  a_cpl_abort: assert property (p_cpl_abort)
    else $error("completer abort flag not set");

  property p_master_poison;
    @(posedge clk) disable iff (reset)
    (!flag_vec[MASTER_POISON_BIT] && !parity_en) |=>
      !flag_vec[MASTER_POISON_BIT];
  endproperty
  a_master_poison: assert property (p_master_poison)
    else $error("bit 8 set while parity response disabled");

  sequence s_status_read;
    cfg_req.rd && (cfg_req.offset == STATUS_OFFSET);
  endsequence
  sequence s_fixed_fields;
    cfg_rsp.ack && (cfg_rsp.rdata[26:16] & 11'h6FF) == 11'h010;
  endsequence
  property p_fixed_status;
    @(posedge clk) disable iff (reset)
    s_status_read |=> s_fixed_fields;
  endproperty
  a_fixed_status: assert property (p_fixed_status)
    else $error("fixed status fields read wrong");

  property p_class_read;
    @(posedge clk) disable iff (reset)
    (cfg_req.rd && cfg_req.offset == CLASS_OFFSET) |=>
      cfg_rsp.rdata == {16'h0604, 8'h00, SILICON_REVISION};
  endproperty
  a_class_read: assert property (p_class_read)
    else $error("class code read wrong");

  property p_sticky_hold;
    @(posedge clk) disable iff (reset)
    (flag_vec[RECEIVED_UR_BIT] && !clr_vec[RECEIVED_UR_BIT]) |=>
      flag_vec[RECEIVED_UR_BIT];
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("flag dropped without a clear");

  property p_set_wins;
    @(posedge clk) disable iff (reset)
    (link_evt.poisoned_tlp && clr_vec[DETECTED_POISON_BIT]) |=>
      flag_vec[DETECTED_POISON_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear won over a new event");

  property p_bad_parity;
    @(posedge clk) disable iff (reset)
    (fwd_valid && fwd_poisoned) |=> fwd_bad_parity;
  endproperty
  a_bad_parity: assert property (p_bad_parity)
    else $error("poisoned data forwarded without bad parity");

  property p_parity_quiet;
    @(posedge clk) disable iff (reset)
    !(fwd_valid && fwd_poisoned) |=> !fwd_bad_parity;
  endproperty
  a_parity_quiet: assert property (p_parity_quiet)
    else $error("bad parity forwarded on a clean beat");

  property p_master_sets;
    @(posedge clk) disable iff (reset)
    (parity_en && (link_evt.poisoned_cpl_data || link_evt.write_poisoned))
      |=> flag_vec[MASTER_POISON_BIT];
  endproperty
  a_master_sets: assert property (p_master_sets)
    else $error("poisoned completion or write did not set bit 8");

  property p_abort_quiet;
    @(posedge clk) disable iff (reset)
    (!link_evt.cpl_abort_sent && !flag_vec[SIGNALED_CA_BIT]) |=>
      !flag_vec[SIGNALED_CA_BIT];
  endproperty
  a_abort_quiet: assert property (p_abort_quiet)
    else $error("bit 11 set without a completer abort");

  // A one written into the top lane clears bit 15 when no event competes
  sequence s_poison_clear;
    cfg_req.wr && (cfg_req.offset == STATUS_OFFSET) &&
      cfg_req.byte_en[3] && cfg_req.wdata[31] && !link_evt.poisoned_tlp;
  endsequence
  property p_poison_clear;
    @(posedge clk) disable iff (reset)
    s_poison_clear |=> !flag_vec[DETECTED_POISON_BIT];
  endproperty
  a_poison_clear: assert property (p_poison_clear)
    else $error("write of one did not clear bit 15");

  property p_lane_keeps;
    @(posedge clk) disable iff (reset)
    (flag_vec[RECEIVED_CA_BIT] &&
      !(cfg_req.wr && cfg_req.byte_en[3] && cfg_req.wdata[28])) |=>
      flag_vec[RECEIVED_CA_BIT];
  endproperty
  a_lane_keeps: assert property (p_lane_keeps)
    else $error("bit 12 dropped without a one written to it");

  property p_status_reset_val;
    @(posedge clk) disable iff (reset)
    (cfg_req.rd && cfg_req.offset == STATUS_OFFSET && flag_vec == 16'h0000)
      |=> cfg_rsp.rdata[31:16] == STATUS_RESET;
  endproperty
  a_status_reset_val: assert property (p_status_reset_val)
    else $error("status with no flags did not read 0010h");

  property p_reset_clears;
    @(posedge clk)
    (reset ##1 reset) |->
      ((flag_vec == 16'h0000) && !cfg_rsp.ack && !fwd_bad_parity);
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("state not cleared while reset held");

  property p_ack_answer;
    @(posedge clk) disable iff (reset)
    (cfg_req.rd || cfg_req.wr) |=> cfg_rsp.ack;
  endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("request not acknowledged one cycle later");

  property p_ack_quiet;
    @(posedge clk) disable iff (reset)
    !(cfg_req.rd || cfg_req.wr) |=> !cfg_rsp.ack;
  endproperty
  a_ack_quiet: assert property (p_ack_quiet)
    else $error("acknowledge without a request");

  property p_rdata_idle;
    @(posedge clk) disable iff (reset)
    !cfg_req.rd |=> (cfg_rsp.rdata == 32'h0000_0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");

  property p_alias_status;
    @(posedge clk) disable iff (reset)
    (cfg_req.rd && cfg_req.offset == COMMAND_OFFSET) |=> s_fixed_fields;
  endproperty
  a_alias_status: assert property (p_alias_status)
    else $error("fixed status fields wrong in the dword read");
endmodule // primary_status_class_regs

// ---- core/sticky_flag.sv ----
// One write-one-to-clear status flag with set priority.
// Assumes set and clear pulses synchronous to clk.
`timescale 1ns/100ps
module sticky_flag (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic set_evt,
  input wire logic clr,
  // State
  output logic flag
);
  typedef struct packed {
    logic flag;
  } state_s;
  state_s st_q;
  state_s st_d;

  // Set wins over a coinciding clear
  always_comb begin
    st_d = st_q;
    if (set_evt) begin
      st_d.flag = 1'b1;
    end else if (clr) begin
      st_d.flag = 1'b0;
    end
  end

  // Flag register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign flag = st_q.flag;
endmodule // sticky_flag

// ---- dv/bridge_primary_status_class_regs_tb.sv ----
// Self-checking bench for the primary status and class code registers.
// Assumes the port model in cfg_port_model.sv and a 25 MHz clock.
`timescale 1ns/100ps
module bridge_primary_status_class_regs_tb;
  import cfg_hdr_pkg::*;
  localparam logic [7:0] REV = 8'hC3; // Arbitrary revision value
  typedef struct packed {
    logic [6:0] evt;
    logic [15:0] cmd;
    logic [15:0] exp;
  } row_s;
  // Event, command, expected status
  row_s rows [9] = '{'{7'h40, 16'h0000, 16'h8010},
    '{7'h20, 16'h0100, 16'h4010}, '{7'h20, 16'h0000, 16'h0010},
    '{7'h10, 16'h0000, 16'h2010}, '{7'h08, 16'h0000, 16'h1010},
    '{7'h04, 16'h0000, 16'h0810}, '{7'h02, 16'h0040, 16'h0110},
    '{7'h01, 16'h0040, 16'h0110}, '{7'h02, 16'h0000, 16'h0010}};
  logic clk, reset, fwd_valid, fwd_poisoned, fwd_bad_parity;
  logic [15:0] command_reg;
  link_event_s link_evt;
  cfg_req_s cfg_req;
  cfg_rsp_s cfg_rsp;
  logic [31:0] d;
  int fails, n_compared;

  primary_status_class_regs #(.SILICON_REVISION(REV))
      u_primary_status_class_regs (.clk(clk), .reset(reset),
      .command_reg(command_reg), .link_evt(link_evt),
      .fwd_valid(fwd_valid), .fwd_poisoned(fwd_poisoned),
      .fwd_bad_parity(fwd_bad_parity), .cfg_req(cfg_req),
      .cfg_rsp(cfg_rsp));
  cfg_port_model u_cfg_port_model (.clk(clk), .cfg_req(cfg_req),
      .cfg_rsp(cfg_rsp));

  // Clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rd(input logic [7:0] off);
    u_cfg_port_model.access(1'b0, off, 4'hF, 32'h0, d);
  endtask
  task wr(input logic [3:0] be, input logic [31:0] wd, input logic [7:0] off);
    u_cfg_port_model.access(1'b1, off, be, wd, d);
  endtask
  // One-cycle link event under a given command value
  task pulse(input logic [6:0] e, input logic [15:0] c);
    @(posedge clk);
    command_reg <= c;
    link_evt <= e;
    @(posedge clk);
    link_evt <= '0;
  endtask
  task give_verdict;
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #(40 * 3000);
    fails++;
    give_verdict;
  end

  initial begin
    reset = 1'b1;
    command_reg = '0;
    link_evt = '0;
    fwd_valid = 1'b0;
    fwd_poisoned = 1'b0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(8'h06);
    check(d, 32'h0010_0000);
    // Each event alone, then cleared by writing ones
    foreach (rows[i]) begin
      pulse(rows[i].evt, rows[i].cmd);
      rd(8'h06);
      check(d, {rows[i].exp, 16'h0});
      wr(4'hC, 32'hFFFF_FFFF, 8'h06);
      rd(8'h04);
      check(d, 32'h0010_0000);
    end
    // All flags, then a write to the low lane only
    pulse(7'h7F, 16'h0140);
    wr(4'h4, 32'hFFFF_FFFF, 8'h06);
    rd(8'h06);
    check(d, 32'hF910_0000);
    wr(4'h8, 32'hFFFF_FFFF, 8'h06);
    rd(8'h06);
    check(d, 32'h0010_0000);
    // Clear and new event on the same edge
    fork
      wr(4'hC, 32'hFFFF_FFFF, 8'h06);
      pulse(7'h40, 16'h0000);
    join
    rd(8'h06);
    check(d, 32'h8010_0000);
    // Class code, write attempt, unmapped place
    rd(8'h08);
    check(d, {8'h06, 8'h04, 8'h00, REV});
    wr(4'hF, 32'h0, 8'h08);
    check(d, 32'h0);
    rd(8'h08);
    check(d, {8'h06, 8'h04, 8'h00, REV});
    rd(8'h10);
    check(d, 32'h0);
    // Poisoned beat forwarded with parity enable off
    @(posedge clk);
    fwd_valid <= 1'b1;
    fwd_poisoned <= 1'b1;
    @(posedge clk);
    fwd_valid <= 1'b0;
    fwd_poisoned <= 1'b0;
    #1 check({31'h0, fwd_bad_parity}, 32'h1);
    // Bad parity lasts only for the poisoned beat
    @(posedge clk);
    #1 check({31'h0, fwd_bad_parity}, 32'h0);
    // Reset in mid-run drops the flags
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(8'h06);
    check(d, 32'h0010_0000);
    give_verdict;
  end
endmodule // bridge_primary_status_class_regs_tb

// ---- dv/cfg_port_model.sv ----
// Model of the upstream port that issues configuration requests.
// Assumes requests are taken on rising clk edges and answered by ack.
`timescale 1ns/100ps
module cfg_port_model (
  // Clock
  input wire logic clk,
  // Configuration access
  output cfg_hdr_pkg::cfg_req_s cfg_req,
  input wire cfg_hdr_pkg::cfg_rsp_s cfg_rsp
);
  import cfg_hdr_pkg::*;
  initial begin
    cfg_req = '0;
  end
  // One request for one taking edge, lines scrambled once released
  task automatic access(input logic wr, input logic [7:0] off,
      input logic [3:0] be, input logic [31:0] wd, output logic [31:0] rdat);
    int i;
    @(posedge clk);
    cfg_req <= '{rd: !wr, wr: wr, offset: off, byte_en: be, wdata: wd};
    @(posedge clk);
    cfg_req <= '{rd: 1'b0, wr: 1'b0, offset: ~off, byte_en: ~be, wdata: ~wd};
    rdat = 'x;
    // Bounded wait for the answer
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      if (cfg_rsp.ack === 1'b1) begin
        rdat = cfg_rsp.rdata;
        break;
      end
    end
  endtask
endmodule // cfg_port_model
